//--- rtl/tcmd_cfg.svh
/*
  Constants for the tag command interpreter: command codes, error codes,
  request flag positions and write cycle timing.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef TCMD_CFG_SVH
`define TCMD_CFG_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define TCMD_CMD_SELECT      8'h25
`define TCMD_CMD_RST_READY   8'h26
`define TCMD_CMD_WR_AFI      8'h27
`define TCMD_CMD_LOCK_AFI    8'h28
`define TCMD_CMD_WR_DSFID    8'h29
`define TCMD_CMD_LOCK_DSFID  8'h2a

// ----------------------------------------------------------------
// Error codes and response flags
// ----------------------------------------------------------------
`define TCMD_ERR_OPTION      8'h03
`define TCMD_ERR_GENERIC     8'h0f
`define TCMD_ERR_RELOCK      8'h11
`define TCMD_ERR_LOCKED      8'h12
`define TCMD_ERR_PROG        8'h13
`define TCMD_ERR_LOCKFAIL    8'h14
`define TCMD_RSP_FLAGS_OK    8'h00
`define TCMD_RSP_FLAGS_ERR   8'h01

// ----------------------------------------------------------------
// Request flag bit positions (bit 0 is b1)
// ----------------------------------------------------------------
`define TCMD_FLG_INVENTORY   2
`define TCMD_FLG_SELECT      4
`define TCMD_FLG_ADDRESS     5
`define TCMD_FLG_OPTION      6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCMD_CLK_MHZ         100
`define TCMD_SLOT_US         302
`define TCMD_SLOT_CYC        (`TCMD_SLOT_US * `TCMD_CLK_MHZ)
`define TCMD_T1NOM_NS        320900
`define TCMD_T1NOM_CYC       ((`TCMD_T1NOM_NS * `TCMD_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCMD_AFI_RST         8'h00
`define TCMD_DSFID_RST       8'h00

`endif

//--- rtl/tcmd_pkg.sv
/*
  Types for the tag command interpreter.
  Assumes tcmd_cfg.svh is on the include path.
*/
`include "tcmd_cfg.svh"

package tcmd_pkg;

  // ----------------------------------------------------------------
  // Decoded request and built response
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  cmd;
    logic [63:0] uid;
    logic [7:0]  data;
  } tcmd_req_t;

  typedef struct packed {
    logic [7:0] flags;
    logic       has_err;
    logic [7:0] err;
    logic [7:0] len;
  } tcmd_rsp_t;

  typedef enum logic [1:0] {TCMD_ST_READY, TCMD_ST_SELECTED, TCMD_ST_QUIET} tcmd_state_t;

  typedef enum logic [1:0] {TCMD_NV_AFI, TCMD_NV_DSFID, TCMD_NV_LAFI, TCMD_NV_LDSFID} tcmd_nvop_t;

endpackage : tcmd_pkg

//--- rtl/tcmd_wcycle.sv
/*
  Write cycle timer: counts the nominal response delay plus N slots.
  Assumes a single clock and a start pulse while idle.
*/
`timescale 1ns/100ps
`default_nettype none

`include "tcmd_cfg.svh"

module tcmd_wcycle #(
  parameter int T1_CYC   = `TCMD_T1NOM_CYC,
  parameter int SLOT_CYC = `TCMD_SLOT_CYC,
  parameter int N_SLOTS  = 16
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import tcmd_pkg::*;

  // ----------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------
  localparam int TOTAL = T1_CYC + N_SLOTS * SLOT_CYC;
  localparam int CW    = $clog2(TOTAL + 1);

  logic [CW-1:0] cnt_q;
  logic          busy_q;
  wire           last = busy_q && (cnt_q == CW'(TOTAL - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q  <= '0;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q  <= cnt_q + CW'(1);
      busy_q <= !last;
    end
  end

  assign busy = busy_q;
  assign done = last;
endmodule : tcmd_wcycle

`default_nettype wire

//--- rtl/tcmd_top.sv
/*
  Command interpreter for Select, Reset to Ready and the AFI / DSFID write
  and lock commands of a contactless tag.
  Assumes a frame decoder delivers a checked request with a one-cycle valid,
  the reader's EOF as a one-cycle pulse, and a framer that adds CRC and
  takes the response on rsp_valid.
*/
`timescale 1ns/100ps
`default_nettype none

`include "tcmd_cfg.svh"

module tcmd_top #(
  parameter logic [63:0] OWN_UID  = 64'he000_0000_1234_5678, // Arbitrary value
  parameter int          T1_CYC   = `TCMD_T1NOM_CYC,
  parameter int          SLOT_CYC = `TCMD_SLOT_CYC,
  parameter int          N_SLOTS  = 16
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                req_valid,
  input  wire tcmd_pkg::tcmd_req_t req,
  input  wire logic                req_uid_present,
  input  wire logic                eof_pulse,
  input  wire logic                nv_fail,
  output logic                     rsp_valid,
  output tcmd_pkg::tcmd_rsp_t      rsp,
  output tcmd_pkg::tcmd_state_t    state,
  output logic [7:0]               afi,
  output logic [7:0]               dsfid,
  output logic                     afi_locked,
  output logic                     dsfid_locked,
  output logic                     busy
);
  import tcmd_pkg::*;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Declared first, since the request decode reads them
  tcmd_state_t state_q;
  logic [7:0]  afi_q;
  logic [7:0]  dsfid_q;
  logic        afi_lk_q;
  logic        dsfid_lk_q;
  logic        busy_q;
  logic        wait_eof_q;
  logic        cyc_done_q;
  logic        nv_fail_q;
  tcmd_nvop_t  op_q;
  logic [7:0]  data_q;
  logic        rsp_valid_q;
  tcmd_rsp_t   rsp_q;
  logic        cyc_busy;
  logic        cyc_done;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire        opt      = req.flags[`TCMD_FLG_OPTION];
  wire        inv      = req.flags[`TCMD_FLG_INVENTORY];
  wire        addr_md  = req.flags[`TCMD_FLG_ADDRESS] || req.cmd == `TCMD_CMD_SELECT;
  wire        sel_md   = req.flags[`TCMD_FLG_SELECT];
  wire        uid_hit  = req_uid_present && (req.uid == OWN_UID);
  wire        is_sel   = req.cmd == `TCMD_CMD_SELECT;
  wire        is_rtr   = req.cmd == `TCMD_CMD_RST_READY;
  wire        is_wafi  = req.cmd == `TCMD_CMD_WR_AFI;
  wire        is_lafi  = req.cmd == `TCMD_CMD_LOCK_AFI;
  wire        is_wds   = req.cmd == `TCMD_CMD_WR_DSFID;
  wire        is_lds   = req.cmd == `TCMD_CMD_LOCK_DSFID;
  wire        is_nv    = is_wafi | is_lafi | is_wds | is_lds;
  wire        ours     = is_sel | is_rtr | is_nv;

  // Quiet tags ignore non-addressed traffic; selected mode needs selection
  wire        in_scope = addr_md ? uid_hit :
                         sel_md  ? (state_q == TCMD_ST_SELECTED) :
                                   (state_q != TCMD_ST_QUIET);
  wire        accept   = req_valid && ours && !busy_q && in_scope;
  wire        sel_miss = req_valid && is_sel && !busy_q && !uid_hit;

  wire        tgt_lock = (is_wafi | is_lafi) ? afi_lk_q : dsfid_lk_q;
  wire        opt_err  = (is_sel | is_rtr) && opt;
  wire        wr_lock  = (is_wafi | is_wds) && tgt_lock;
  wire        lk_again = (is_lafi | is_lds) && tgt_lock;
  wire        any_err  = opt_err | inv | wr_lock | lk_again;
  wire [7:0]  pre_err  = opt_err  ? `TCMD_ERR_OPTION :
                         wr_lock  ? `TCMD_ERR_LOCKED :
                         lk_again ? `TCMD_ERR_RELOCK :
                                    `TCMD_ERR_GENERIC;
  wire        nv_go    = accept && is_nv && !any_err;

  // ----------------------------------------------------------------
  // Write cycle timer
  // ----------------------------------------------------------------
  tcmd_wcycle #(
    .T1_CYC   (T1_CYC),
    .SLOT_CYC (SLOT_CYC),
    .N_SLOTS  (N_SLOTS)
  ) u_wcycle (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (nv_go),
    .busy    (cyc_busy),
    .done    (cyc_done)
  );

  // Cycle end and reader EOF may arrive in either order
  wire        cyc_end  = cyc_done || cyc_done_q;
  wire        eof_ok   = !wait_eof_q || eof_pulse;
  wire        finish   = busy_q && !cyc_busy && cyc_end && eof_ok;
  wire        fail_any = nv_fail_q || nv_fail;
  wire        is_lkop  = (op_q == TCMD_NV_LAFI) || (op_q == TCMD_NV_LDSFID);
  wire [7:0]  nv_err   = is_lkop ? `TCMD_ERR_LOCKFAIL : `TCMD_ERR_PROG;

  // ----------------------------------------------------------------
  // Tag state and selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= TCMD_ST_READY;
    end else if (accept && !any_err && is_rtr) begin
      state_q <= TCMD_ST_READY;
    end else if (accept && !any_err && is_sel) begin
      state_q <= TCMD_ST_SELECTED;
    end else if (sel_miss && state_q == TCMD_ST_SELECTED) begin
      state_q <= TCMD_ST_READY;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile operation sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_q     <= 1'b0;
      wait_eof_q <= 1'b0;
      cyc_done_q <= 1'b0;
      nv_fail_q  <= 1'b0;
      op_q       <= TCMD_NV_AFI;
      data_q     <= 8'h00;
    end else if (nv_go) begin
      busy_q     <= 1'b1;
      wait_eof_q <= opt;
      cyc_done_q <= 1'b0;
      nv_fail_q  <= 1'b0;
      op_q       <= is_wafi ? TCMD_NV_AFI : is_wds ? TCMD_NV_DSFID :
                    is_lafi ? TCMD_NV_LAFI : TCMD_NV_LDSFID;
      data_q     <= req.data;
    end else if (finish) begin
      busy_q     <= 1'b0;
      wait_eof_q <= 1'b0;
      cyc_done_q <= 1'b0;
    end else begin
      cyc_done_q <= cyc_end;
      nv_fail_q  <= fail_any && busy_q;
      // EOF seen before the cycle ends is kept
      if (eof_pulse) begin
        wait_eof_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stored values, committed only when the cycle ends cleanly
  // ----------------------------------------------------------------
  wire commit = finish && !fail_any;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      afi_q      <= `TCMD_AFI_RST;
      dsfid_q    <= `TCMD_DSFID_RST;
      afi_lk_q   <= 1'b0;
      dsfid_lk_q <= 1'b0;
    end else if (commit) begin
      unique case (op_q)
        TCMD_NV_AFI:    afi_q      <= data_q;
        TCMD_NV_DSFID:  dsfid_q    <= data_q;
        TCMD_NV_LAFI:   afi_lk_q   <= 1'b1;
        TCMD_NV_LDSFID: dsfid_lk_q <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Response builder; CRC is appended by the framer
  // ----------------------------------------------------------------
  wire imm_rsp = accept && (any_err || !is_nv);
  wire imm_err = any_err;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else if (imm_rsp) begin
      rsp_valid_q   <= 1'b1;
      rsp_q.flags   <= imm_err ? `TCMD_RSP_FLAGS_ERR : `TCMD_RSP_FLAGS_OK;
      rsp_q.has_err <= imm_err;
      rsp_q.err     <= imm_err ? pre_err : 8'h00;
      rsp_q.len     <= imm_err ? 8'd4 : 8'd3;
    end else if (finish) begin
      rsp_valid_q   <= 1'b1;
      rsp_q.flags   <= fail_any ? `TCMD_RSP_FLAGS_ERR : `TCMD_RSP_FLAGS_OK;
      rsp_q.has_err <= fail_any;
      rsp_q.err     <= fail_any ? nv_err : 8'h00;
      rsp_q.len     <= fail_any ? 8'd4 : 8'd3;
    end else begin
      rsp_valid_q <= 1'b0;
    end
  end

  assign rsp_valid    = rsp_valid_q;
  assign rsp          = rsp_q;
  assign state        = state_q;
  assign afi          = afi_q;
  assign dsfid        = dsfid_q;
  assign afi_locked   = afi_lk_q;
  assign dsfid_locked = dsfid_lk_q;
  assign busy         = busy_q;
endmodule : tcmd_top

`default_nettype wire

//--- verif/tcmd_reader.sv
/*
  Reader model: issues decoded requests and EOF strobes toward the tag.
  Assumes the bench calls its tasks right after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module tcmd_reader (
  input  wire logic           clk_sys,
  output tcmd_pkg::tcmd_req_t req,
  output logic                req_valid,
  output logic                req_uid_present,
  output logic                eof_pulse
);
  import tcmd_pkg::*;

  initial begin
    req             = '0;
    req_valid       = 1'b0;
    req_uid_present = 1'b0;
    eof_pulse       = 1'b0;
  end

  // Frame goes on the next rising edge and holds valid for one cycle
  // Released fields invert so stale values cannot pass for fresh ones
  task automatic send(input logic [7:0] fl, input logic [7:0] cm,
                      input logic [63:0] id, input logic [7:0] dt, input logic up);
    @(posedge clk_sys);
    req_valid       <= 1'b1;
    req             <= '{fl, cm, id, dt};
    req_uid_present <= up;
    @(posedge clk_sys);
    req_valid       <= 1'b0;
    req             <= ~req;
    req_uid_present <= ~up;
  endtask : send

  task automatic eof();
    @(posedge clk_sys);
    eof_pulse <= 1'b1;
    @(posedge clk_sys);
    eof_pulse <= 1'b0;
  endtask : eof
endmodule : tcmd_reader

`default_nettype wire

//--- verif/tcmd_top_assertions.sv
/*
  Port checker for the command interpreter.
  Assumes binding into tcmd_top with its parameters.
*/
`timescale 1ns/100ps
`default_nettype none

module tcmd_top_assertions #(
  parameter logic [63:0] OWN_UID  = 64'h0,
  parameter int          T1_CYC   = 4,
  parameter int          SLOT_CYC = 3,
  parameter int          N_SLOTS  = 2
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  req_valid,
  input wire tcmd_pkg::tcmd_req_t   req,
  input wire logic                  req_uid_present,
  input wire logic                  eof_pulse,
  input wire logic                  rsp_valid,
  input wire tcmd_pkg::tcmd_rsp_t   rsp,
  input wire tcmd_pkg::tcmd_state_t state,
  input wire logic                  afi_locked,
  input wire logic                  busy
);
  import tcmd_pkg::*;
  localparam int WT = T1_CYC + N_SLOTS * SLOT_CYC;
  logic        addr_w;
  logic        hit;
  logic        opt_q;
  logic        eof_q;
  logic [31:0] cnt_q;

  assign addr_w = req.flags[5] || req.cmd == 8'h25;
  assign hit    = req_valid && !busy && (addr_w ? req_uid_present && req.uid == OWN_UID
                                                : !req.flags[4] || state == TCMD_ST_SELECTED);

  // Long write cycles are counted here, too long to unroll
  always_ff @(posedge clk_sys) begin
    if (!rst_n || rsp_valid) begin
      opt_q <= 1'b0;
      eof_q <= 1'b0;
    end else begin
      opt_q <= opt_q || (hit && req.cmd inside {[8'h27:8'h2a]} && req.flags[6]);
      eof_q <= eof_q || eof_pulse;
    end
  end

  always_ff @(posedge clk_sys) begin
    cnt_q <= (rst_n && busy) ? cnt_q + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  rsp_form_a: assert property (rsp_valid |-> rsp.len == (rsp.has_err ? 8'h04 : 8'h03)
    && rsp.flags == {7'h0, rsp.has_err}) else $error("bad response form");
  miss_quiet_a: assert property (req_valid && !busy && addr_w && req.uid != OWN_UID
    |=> !rsp_valid) else $error("reply to foreign uid");
  sel_back_a: assert property (req_valid && !busy && req.cmd == 8'h25
    && req.uid != OWN_UID |=> state == TCMD_ST_READY) else $error("select miss kept state");
  opt_err_a: assert property (hit && req.cmd inside {8'h25, 8'h26} && req.flags[6]
    |=> rsp_valid && rsp.err == 8'h03) else $error("option not refused");
  rtr_ok_a: assert property (hit && req.cmd == 8'h26 && !req.flags[6] && !req.flags[2]
    |=> rsp_valid && !rsp.has_err && state == TCMD_ST_READY) else $error("reset to ready");
  inv_err_a: assert property (hit && req.cmd == 8'h26 && req.flags[2] && !req.flags[6]
    |=> rsp_valid && rsp.err == 8'h0f) else $error("inventory flag not refused");
  wr_locked_a: assert property (hit && req.cmd == 8'h27 && afi_locked
    |=> rsp_valid && rsp.err == 8'h12) else $error("write to locked value");
  relock_a: assert property (hit && req.cmd == 8'h28 && afi_locked
    |=> rsp_valid && rsp.err == 8'h11) else $error("relock not refused");
  wt_len_a: assert property ($fell(busy) |-> cnt_q >= WT)
    else $error("write cycle short");
  rsp_after_a: assert property ($fell(busy) |-> rsp_valid)
    else $error("no response after write");
  eof_wait_a: assert property (rsp_valid && opt_q && !rsp.has_err |-> eof_q)
    else $error("reply before eof");

  cover property (hit && req.cmd == 8'h25);
  cover property ($fell(busy));
  cover property (rsp_valid && opt_q);
endmodule : tcmd_top_assertions

bind tcmd_top tcmd_top_assertions #(
  .OWN_UID(OWN_UID), .T1_CYC(T1_CYC), .SLOT_CYC(SLOT_CYC), .N_SLOTS(N_SLOTS)
) tcmd_top_assertions_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .req_uid_present(req_uid_present), .eof_pulse(eof_pulse), .rsp_valid(rsp_valid),
  .rsp(rsp), .state(state), .afi_locked(afi_locked), .busy(busy)
);

`default_nettype wire

//--- verif/tcmd_top_tb.sv
/*
  Self-checking bench for tcmd_top with a short write timer.
  Assumes the reader model drives all request inputs.
*/
`timescale 1ns/100ps
`default_nettype none

module tcmd_top_tb;
  import tcmd_pkg::*;
  localparam logic [63:0] UID = 64'he000_0000_0000_00a5; // Arbitrary value
  localparam int          WT  = 10;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        nv_fail = 1'b0;
  logic        req_valid, req_uid_present, eof_pulse, rsp_valid;
  logic        afi_locked, dsfid_locked, busy;
  logic [7:0]  afi, dsfid;
  tcmd_req_t   req;
  tcmd_rsp_t   rsp;
  tcmd_state_t state;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          lat;

  always #5 clk_sys = ~clk_sys;

  tcmd_reader tcmd_reader_inst (.clk_sys(clk_sys), .req(req), .req_valid(req_valid),
    .req_uid_present(req_uid_present), .eof_pulse(eof_pulse));
  tcmd_top #(.OWN_UID(UID), .T1_CYC(4), .SLOT_CYC(3), .N_SLOTS(2)) tcmd_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_uid_present(req_uid_present), .eof_pulse(eof_pulse), .nv_fail(nv_fail),
    .rsp_valid(rsp_valid), .rsp(rsp), .state(state), .afi(afi), .dsfid(dsfid),
    .afi_locked(afi_locked), .dsfid_locked(dsfid_locked), .busy(busy));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Response pulse lasts one cycle, so look before the first edge too
  task automatic rx(input int n, output int l);
    l = -1;
    for (int i = 0; i <= n; i++) begin
      #1;
      if (rsp_valid === 1'b1) begin
        l = i;
        break;
      end
      @(posedge clk_sys);
    end
  endtask : rx

  // Code ff means silence, 00 means success
  task automatic xfer(input logic [7:0] fl, input logic [7:0] cm, input logic [7:0] dt,
                      input logic [63:0] id, input int n, input logic [7:0] err);
    tcmd_reader_inst.send(fl, cm, id, dt, fl[5] | (cm == 8'h25));
    rx(n, lat);
    if (err === 8'hff)
      chk("silence", lat, -1);
    else if (lat < 0) begin
      num_errors++;
      end_of_test();
    end else begin
      chk("flags", rsp.flags, {7'h0, err != 8'h00});
      chk("len", rsp.len, err != 8'h00 ? 8'h04 : 8'h03);
      chk("has_err", rsp.has_err, err != 8'h00);
      chk("err", rsp.err, err);
      chk("busy", busy, 1'b0);
    end
  endtask : xfer

  task automatic t_sel_rtr();
    xfer(8'h20, 8'h25, 8'h00, UID, 2, 8'h00);
    xfer(8'h60, 8'h25, 8'h00, UID, 2, 8'h03);
    xfer(8'h60, 8'h26, 8'h00, UID, 2, 8'h03);
    xfer(8'h20, 8'h26, 8'h00, ~UID, 4, 8'hff);
    xfer(8'h04, 8'h26, 8'h00, UID, 2, 8'h0f);
    chk("state", state, TCMD_ST_SELECTED);
    xfer(8'h20, 8'h26, 8'h00, UID, 2, 8'h00);
    chk("state", state, TCMD_ST_READY);
    xfer(8'h20, 8'h25, 8'h00, UID, 2, 8'h00);
    xfer(8'h20, 8'h25, 8'h00, ~UID, 4, 8'hff);
    chk("state", state, TCMD_ST_READY);
  endtask : t_sel_rtr

  task automatic t_fail();
    @(posedge clk_sys);
    nv_fail <= 1'b1;
    xfer(8'h00, 8'h27, 8'h11, UID, WT + 4, 8'h13);
    chk("afi", afi, 8'h00);
    xfer(8'h00, 8'h2a, 8'h00, UID, WT + 4, 8'h14);
    chk("dsfid_locked", dsfid_locked, 1'b0);
    @(posedge clk_sys);
    nv_fail <= 1'b0;
  endtask : t_fail

  task automatic t_write();
    xfer(8'h00, 8'h27, 8'h5a, UID, WT + 4, 8'h00);
    chk("write_time", lat, WT + 1);
    chk("afi", afi, 8'h5a);
    xfer(8'h40, 8'h29, 8'ha3, UID, WT + 5, 8'hff);
    tcmd_reader_inst.eof();
    rx(4, lat);
    chk("eof_rsp", {lat >= 0, rsp.has_err}, 2'b10);
    if (lat < 0)
      end_of_test();
    chk("dsfid", dsfid, 8'ha3);
  endtask : t_write

  task automatic t_lock();
    xfer(8'h00, 8'h28, 8'h00, UID, WT + 4, 8'h00);
    chk("afi_locked", afi_locked, 1'b1);
    xfer(8'h00, 8'h28, 8'h00, UID, 2, 8'h11);
    xfer(8'h40, 8'h27, 8'h77, UID, 2, 8'h12);
    chk("afi", afi, 8'h5a);
    xfer(8'h00, 8'h2a, 8'h00, UID, WT + 4, 8'h00);
    xfer(8'h00, 8'h29, 8'h01, UID, 2, 8'h12);
    chk("dsfid", dsfid, 8'ha3);
  endtask : t_lock

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_sel_rtr();
    t_fail();
    t_write();
    t_lock();
    end_of_test();
  end
endmodule : tcmd_top_tb

`default_nettype wire
